/* File: design/sfb_ctrl.sv */
// SDRAM bus-sharing controller with fly-by transfers
// Notes on behaviour
// - Fly-by read: SDRAM read, I/O write strobe
// - Fly-by write: SDRAM write, I/O read, enable
// - Fly-by uses normal SDRAM command pins
// - Only DMA channel zero runs fly-by
// - One transaction per request falling edge
// - Only bus owner drives I/O strobes
// - Host request answered with host grant
// - Self-refresh entered in the same cycle as host grant
// - No SDRAM access while host grant low
// - Host release exits self-refresh, resumes
// - Eight processors share; one drives
// - Non-master decodes mode, refresh, self-refresh
// - Only cluster id zero sets mode
// - Mode set once before first access
// - Slave decrements counter on seen refresh
// - Seen self-refresh freezes counter until exit
// - Precharge all before releasing the bus
// - New owner starts with row activate
// - Host request stops burst, then precharges
// - Clock enable falls at self-refresh entry
`timescale 1ns/100ps
`default_nettype none
module sfb_ctrl #(
  parameter int PWRUP_CYCLES = sfb_pkg::PWRUP_CYC
) (
  // SDRAM clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Link clock of the I/O device
  input wire logic clk_io_i,
  // Static configuration
  input wire logic [2:0] cluster_id_i,
  input wire logic [1:0] cas_lat_i,
  input wire logic [1:0] flyby_chan_i,
  input wire logic flyby_wr_i,
  input wire logic [13:0] flyby_addr_i,
  // Bus arbitration and host
  input wire logic bus_own_i,
  input wire logic host_bus_req_n_i,
  output logic host_bus_grant_n_o,
  output logic bus_master_o,
  // DMA request from the I/O device
  input wire logic dma_req_ch_zero_n_i,
  // SDRAM command pins, driven side
  output logic mem_clk_en_o,
  output logic [3:0] mem_select_n_o,
  output logic mem_ras_n_o,
  output logic mem_cas_n_o,
  output logic mem_write_en_n_o,
  output logic [13:0] mem_addr_o,
  output logic mem_cmd_oe_o,
  // SDRAM command pins, monitored side
  input wire logic mem_clk_en_i,
  input wire logic [3:0] mem_select_n_i,
  input wire logic mem_ras_n_i,
  input wire logic mem_cas_n_i,
  input wire logic mem_write_en_n_i,
  // I/O device strobes
  output logic io_read_strobe_n_o,
  output logic io_write_strobe_n_o,
  output logic io_device_enable_n_o,
  output logic io_oe_o,
  // Status
  output logic sdram_ready_o,
  output logic flyby_done_o
);
  typedef struct packed {
    sfb_pkg::sfb_state_e state;
    logic [1:0] after;
    logic [7:0] wait_cnt;
    logic [7:0] ras_cnt;
    logic [11:0] ref_cnt;
    logic ref_frozen;
    logic [3:0] init_refs;
    logic [15:0] pwr_cnt;
    logic mrs_done;
    logic master;
    logic grant_n;
    logic cke;
    logic [3:0] sel_n;
    sfb_pkg::sfb_cmd_e cmd;
    logic [13:0] addr;
    logic go_tgl;
    logic wr_dir;
    logic done_seen;
    logic dmar_prev;
    logic pend;
    logic flyby_done;
  } sfb_ctrl_s;

  localparam sfb_ctrl_s CTRL_RST = '{
    state: sfb_pkg::ST_PWRUP, after: sfb_pkg::AFT_IDLE,
    wait_cnt: 8'h00, ras_cnt: 8'h00, ref_cnt: sfb_pkg::REF_PERIOD_CYC,
    ref_frozen: 1'b0, init_refs: 4'h0, pwr_cnt: 16'(PWRUP_CYCLES),
    mrs_done: 1'b0, master: 1'b0, grant_n: 1'b1, cke: 1'b1,
    sel_n: sfb_pkg::SEL_NONE, cmd: sfb_pkg::CMD_NOP,
    addr: sfb_pkg::ADDR_ALL_BANKS, go_tgl: 1'b0, wr_dir: 1'b0,
    done_seen: 1'b0, dmar_prev: 1'b1, pend: 1'b0, flyby_done: 1'b0
  };

  sfb_ctrl_s q;
  sfb_ctrl_s d;
  sfb_xfer_if xf ();

  logic hbr_s;
  logic dmar_s;
  logic own_s;
  logic done_s;
  logic cke_s;
  logic [3:0] sel_s;
  logic [2:0] bus_cmd_s;
  logic dmar_fall;
  logic io_done;
  logic sel_any;
  logic ref_det;
  logic sref_det;
  logic mrs_det;
  logic [13:0] mode_word;

  // Pins from other parties pass two flops first
  sfb_sync #(.WIDTH(3), .RST_VAL(3'h6)) u_ctl_sync (
    .clk_i(clk_sys_i), .rst_i(sys_rst_i),
    .d_i({host_bus_req_n_i, dma_req_ch_zero_n_i, bus_own_i}),
    .q_o({hbr_s, dmar_s, own_s})
  );
  sfb_sync #(.WIDTH(8), .RST_VAL(8'hFF)) u_bus_sync (
    .clk_i(clk_sys_i), .rst_i(sys_rst_i),
    .d_i({mem_clk_en_i, mem_select_n_i, mem_ras_n_i, mem_cas_n_i,
          mem_write_en_n_i}),
    .q_o({cke_s, sel_s, bus_cmd_s})
  );
  sfb_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_done_sync (
    .clk_i(clk_sys_i), .rst_i(sys_rst_i), .d_i(xf.done_tgl),
    .q_o(done_s)
  );

  sfb_io_strobe u_io (
    .clk_io_i(clk_io_i),
    .sys_rst_i(sys_rst_i),
    .xf(xf),
    .io_read_strobe_n_o(io_read_strobe_n_o),
    .io_write_strobe_n_o(io_write_strobe_n_o),
    .io_device_enable_n_o(io_device_enable_n_o),
    .io_oe_o(io_oe_o)
  );

  assign dmar_fall = q.dmar_prev & ~dmar_s;
  assign io_done = done_s ^ q.done_seen;
  // Bus decode of another master's commands
  assign sel_any = ~&sel_s;
  assign ref_det = sel_any & cke_s & (bus_cmd_s == 3'(sfb_pkg::CMD_REF));
  assign sref_det = sel_any & ~cke_s & (bus_cmd_s == 3'(sfb_pkg::CMD_REF));
  assign mrs_det = sel_any & (bus_cmd_s == 3'(sfb_pkg::CMD_MRS));
  // Full-page sequential burst, latency from configuration
  assign mode_word = (14'(sfb_pkg::MODE_BL_FULL) << sfb_pkg::MODE_BL_LSB)
    | (14'({1'b0, cas_lat_i}) << sfb_pkg::MODE_CL_LSB);

  always_comb begin
    d = q;
    d.cmd = sfb_pkg::CMD_NOP;
    d.flyby_done = 1'b0;
    d.dmar_prev = dmar_s;
    d.done_seen = done_s;
    if (q.wait_cnt != 8'h00) begin
      d.wait_cnt = q.wait_cnt - 8'h01;
    end
    if (q.ras_cnt != 8'h00) begin
      d.ras_cnt = q.ras_cnt - 8'h01;
    end
    // Own refresh timebase runs only while driving a live SDRAM
    if (q.master && q.state != sfb_pkg::ST_HOST
        && q.ref_cnt != 12'h000) begin
      d.ref_cnt = q.ref_cnt - 12'h001;
    end
    if (!q.master) begin
      if (mrs_det) begin
        d.mrs_done = 1'b1;
      end
      if (sref_det) begin
        d.ref_frozen = 1'b1;
      end else if (q.ref_frozen && cke_s) begin
        d.ref_frozen = 1'b0;
      end
      if (ref_det && !q.ref_frozen && q.ref_cnt != 12'h000) begin
        d.ref_cnt = q.ref_cnt - 12'h001;
      end
    end
    case (q.state)
      sfb_pkg::ST_PWRUP: begin
        if (q.pwr_cnt != 16'h0000) begin
          d.pwr_cnt = q.pwr_cnt - 16'h0001;
        end else begin
          d.state = sfb_pkg::ST_SLAVE;
        end
      end
      sfb_pkg::ST_SLAVE: begin
        if (own_s) begin
          d.master = 1'b1;
          d.state = sfb_pkg::ST_IDLE;
        end
      end
      sfb_pkg::ST_IDLE: begin
        if (q.wait_cnt == 8'h00) begin
          if (!own_s) begin
            d.after = sfb_pkg::AFT_REL;
            d.state = sfb_pkg::ST_PREA;
          end else if (!hbr_s) begin
            d.after = sfb_pkg::AFT_SREF;
            d.state = sfb_pkg::ST_PREA;
          end else if (!q.mrs_done) begin
            if (cluster_id_i == sfb_pkg::MODE_SET_ID) begin
              d.state = sfb_pkg::ST_INIT_PRE;
            end
          end else if (q.ref_cnt == 12'h000) begin
            d.cmd = sfb_pkg::CMD_REF;
            d.ref_cnt = sfb_pkg::REF_PERIOD_CYC;
            d.wait_cnt = sfb_pkg::T_RC_CYC - 8'h01;
          end else if (q.pend) begin
            // Banks are all closed here, so a row is opened first
            d.cmd = sfb_pkg::CMD_ACT;
            d.addr = flyby_addr_i;
            d.pend = 1'b0;
            d.wr_dir = flyby_wr_i;
            d.ras_cnt = sfb_pkg::T_RAS_CYC - 8'h01;
            d.wait_cnt = sfb_pkg::T_RCD_CYC - 8'h01;
            d.state = sfb_pkg::ST_CMD;
          end
        end
      end
      sfb_pkg::ST_CMD: begin
        if (q.wait_cnt == 8'h00) begin
          d.cmd = q.wr_dir ? sfb_pkg::CMD_WR : sfb_pkg::CMD_RD;
          d.addr = flyby_addr_i & ~sfb_pkg::ADDR_ALL_BANKS;
          d.go_tgl = ~q.go_tgl;
          d.state = sfb_pkg::ST_XFER;
        end
      end
      sfb_pkg::ST_XFER: begin
        if (!hbr_s) begin
          // Word is abandoned; the host takes precedence
          d.cmd = sfb_pkg::CMD_BST;
          d.after = sfb_pkg::AFT_SREF;
          d.state = sfb_pkg::ST_PREA;
        end else if (io_done) begin
          d.cmd = sfb_pkg::CMD_BST;
          d.flyby_done = 1'b1;
          d.after = sfb_pkg::AFT_IDLE;
          d.state = sfb_pkg::ST_PREA;
        end
      end
      sfb_pkg::ST_PREA: begin
        if (q.wait_cnt == 8'h00 && q.ras_cnt == 8'h00) begin
          d.cmd = sfb_pkg::CMD_PRE;
          d.addr = sfb_pkg::ADDR_ALL_BANKS;
          d.wait_cnt = sfb_pkg::T_RP_CYC - 8'h01;
          d.state = sfb_pkg::ST_POST;
        end
      end
      sfb_pkg::ST_POST: begin
        if (q.wait_cnt == 8'h00) begin
          case (q.after)
            sfb_pkg::AFT_SREF: begin
              d.cmd = sfb_pkg::CMD_REF;
              d.cke = 1'b0;
              d.grant_n = 1'b0;
              d.state = sfb_pkg::ST_HOST;
            end
            sfb_pkg::AFT_REL: begin
              d.master = 1'b0;
              d.state = sfb_pkg::ST_SLAVE;
            end
            default: begin
              d.state = sfb_pkg::ST_IDLE;
            end
          endcase
        end
      end
      sfb_pkg::ST_HOST: begin
        // Fly-by requests are dropped while the host owns the bus
        if (hbr_s) begin
          d.grant_n = 1'b1;
          d.cke = 1'b1;
          d.wait_cnt = sfb_pkg::T_XSR_CYC - 8'h01;
          d.state = sfb_pkg::ST_SRX;
        end
      end
      sfb_pkg::ST_SRX: begin
        if (q.wait_cnt == 8'h00) begin
          d.ref_cnt = sfb_pkg::REF_PERIOD_CYC;
          d.state = sfb_pkg::ST_IDLE;
        end
      end
      sfb_pkg::ST_INIT_PRE: begin
        d.cmd = sfb_pkg::CMD_PRE;
        d.addr = sfb_pkg::ADDR_ALL_BANKS;
        d.init_refs = sfb_pkg::INIT_REF_NUM;
        d.wait_cnt = sfb_pkg::T_RP_CYC - 8'h01;
        d.state = sfb_pkg::ST_INIT_REF;
      end
      sfb_pkg::ST_INIT_REF: begin
        if (q.wait_cnt == 8'h00) begin
          if (q.init_refs != 4'h0) begin
            d.cmd = sfb_pkg::CMD_REF;
            d.init_refs = q.init_refs - 4'h1;
            d.wait_cnt = sfb_pkg::T_RC_CYC - 8'h01;
          end else begin
            d.state = sfb_pkg::ST_INIT_MRS;
          end
        end
      end
      sfb_pkg::ST_INIT_MRS: begin
        d.cmd = sfb_pkg::CMD_MRS;
        d.addr = mode_word;
        d.mrs_done = 1'b1;
        d.ref_cnt = sfb_pkg::REF_PERIOD_CYC;
        d.wait_cnt = sfb_pkg::T_MRD_CYC - 8'h01;
        d.state = sfb_pkg::ST_IDLE;
      end
      default: begin
        d = CTRL_RST;
      end
    endcase
    // A new edge wins over the clear taken at activate
    if (dmar_fall && flyby_chan_i == sfb_pkg::FLYBY_CHAN
        && q.master && q.grant_n) begin
      d.pend = 1'b1;
    end
    d.sel_n = d.master ? sfb_pkg::SEL_ACTIVE : sfb_pkg::SEL_NONE;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  assign xf.go_tgl = q.go_tgl;
  assign xf.wr_dir = q.wr_dir;
  assign xf.master = q.master;

  assign host_bus_grant_n_o = q.grant_n;
  assign bus_master_o = q.master;
  assign mem_clk_en_o = q.cke;
  assign mem_select_n_o = q.sel_n;
  assign mem_ras_n_o = q.cmd[2];
  assign mem_cas_n_o = q.cmd[1];
  assign mem_write_en_n_o = q.cmd[0];
  assign mem_addr_o = q.addr;
  assign mem_cmd_oe_o = q.master;
  assign sdram_ready_o = q.mrs_done;
  assign flyby_done_o = q.flyby_done;
endmodule
`default_nettype wire

/* File: pkg/sfb_pkg.sv */
// Shared constants and types for the fly-by SDRAM bus-sharing controller
package sfb_pkg;
  // Clock rate and power-up wait
  localparam int CLK_MHZ = 125;
  localparam int PWRUP_US = 200;
  localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
  // SDRAM timing counts in SDRAM clock cycles
  localparam logic [11:0] REF_PERIOD_CYC = 12'hE74;
  localparam logic [7:0] T_RP_CYC = 8'h02;
  localparam logic [7:0] T_RAS_CYC = 8'h05;
  localparam logic [7:0] T_RC_CYC = T_RAS_CYC + T_RP_CYC;
  localparam logic [7:0] T_RCD_CYC = 8'h02;
  localparam logic [7:0] T_MRD_CYC = 8'h02;
  localparam logic [7:0] T_XSR_CYC = T_RC_CYC + T_RP_CYC;
  localparam logic [3:0] INIT_REF_NUM = 4'h8;
  // Link-side strobe width in link clock cycles
  localparam logic [3:0] IO_STROBE_CYC = 4'h2;
  // Identity and channel codes
  localparam logic [2:0] MODE_SET_ID = 3'h0;
  localparam logic [1:0] FLYBY_CHAN = 2'h0;
  // Mode word layout
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] MODE_BL_FULL = 3'h7;
  // Address and select values
  localparam logic [13:0] ADDR_ALL_BANKS = 14'h0400;
  localparam logic [3:0] SEL_ACTIVE = 4'hE;
  localparam logic [3:0] SEL_NONE = 4'hF;
  // What follows a precharge-all
  localparam logic [1:0] AFT_IDLE = 2'h0;
  localparam logic [1:0] AFT_SREF = 2'h1;
  localparam logic [1:0] AFT_REL = 2'h2;
  // Commands as {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_BST = 3'h6, CMD_NOP = 3'h7
  } sfb_cmd_e;
  typedef enum logic [3:0] {
    ST_PWRUP = 4'h0, ST_SLAVE = 4'h1, ST_IDLE = 4'h3, ST_CMD = 4'h2,
    ST_XFER = 4'h6, ST_PREA = 4'h7, ST_POST = 4'h5, ST_HOST = 4'h4,
    ST_SRX = 4'hC, ST_INIT_PRE = 4'hD, ST_INIT_REF = 4'hF,
    ST_INIT_MRS = 4'hE
  } sfb_state_e;
endpackage

/* File: pkg/sfb_xfer_if.sv */
// Handshake between the SDRAM-clock controller and the link-clock strobes
`timescale 1ns/100ps
`default_nettype none
interface sfb_xfer_if;
  logic go_tgl;
  logic wr_dir;
  logic master;
  logic done_tgl;
  modport ctrl (output go_tgl, output wr_dir, output master,
                input done_tgl);
  modport io (input go_tgl, input wr_dir, input master, output done_tgl);
endinterface
`default_nettype wire

/* File: design/sfb_sync.sv */
// Two-flop synchroniser of parameterised width
`timescale 1ns/100ps
`default_nettype none
module sfb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } sfb_sync_s;
  sfb_sync_s q;
  sfb_sync_s d;

  // First stage feeds only the second
  always_comb begin
    d.meta = d_i;
    d.stab = q.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign q_o = q.stab;
endmodule
`default_nettype wire

/* File: design/sfb_io_strobe.sv */
// Link-clock strobes toward the external I/O device
`timescale 1ns/100ps
`default_nettype none
module sfb_io_strobe (
  // Link clock and system reset
  input wire logic clk_io_i,
  input wire logic sys_rst_i,
  // Handshake with the controller
  sfb_xfer_if.io xf,
  // I/O device pins
  output logic io_read_strobe_n_o,
  output logic io_write_strobe_n_o,
  output logic io_device_enable_n_o,
  output logic io_oe_o
);
  typedef struct packed {
    logic go_seen;
    logic [3:0] cnt;
    logic rd_n;
    logic wr_n;
    logic en_n;
    logic oe;
    logic done_tgl;
  } sfb_io_s;
  localparam sfb_io_s IO_RST = '{1'b0, 4'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  sfb_io_s q;
  sfb_io_s d;
  logic rst_s;
  logic go_s;
  logic master_s;
  logic wr_s;

  sfb_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_rst (
    .clk_i(clk_io_i), .rst_i(1'b0), .d_i(sys_rst_i), .q_o(rst_s)
  );
  sfb_sync #(.WIDTH(3), .RST_VAL(3'h0)) u_in (
    .clk_i(clk_io_i), .rst_i(rst_s),
    .d_i({xf.go_tgl, xf.master, xf.wr_dir}),
    .q_o({go_s, master_s, wr_s})
  );

  always_comb begin
    d = q;
    d.oe = master_s;
    if (q.cnt != 4'h0) begin
      d.cnt = q.cnt - 4'h1;
      if (q.cnt == 4'h1) begin
        d.rd_n = 1'b1;
        d.wr_n = 1'b1;
        d.en_n = 1'b1;
        d.done_tgl = ~q.done_tgl;
      end
    end else if (go_s != q.go_seen) begin
      // Direction is held steady by the controller until done returns
      d.go_seen = go_s;
      d.cnt = sfb_pkg::IO_STROBE_CYC;
      if (wr_s) begin
        d.rd_n = 1'b0;
        d.en_n = 1'b0;
      end else begin
        d.wr_n = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_io_i) begin
    if (rst_s) begin
      q <= IO_RST;
    end else begin
      q <= d;
    end
  end

  assign xf.done_tgl = q.done_tgl;
  assign io_read_strobe_n_o = q.rd_n;
  assign io_write_strobe_n_o = q.wr_n;
  assign io_device_enable_n_o = q.en_n;
  assign io_oe_o = q.oe;
endmodule
`default_nettype wire

/* File: tb/sfb_properties.sv */
// Port checks for the fly-by SDRAM bus-sharing controller
`timescale 1ns/100ps
`default_nettype none
module sfb_props #(
  parameter int PWRUP_CYCLES = 20
) (
  // Clocks and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic clk_io_i,
  // Configuration
  input wire logic [2:0] cluster_id_i,
  input wire logic [1:0] flyby_chan_i,
  // Arbitration and SDRAM pins
  input wire logic host_bus_grant_n_o,
  input wire logic bus_master_o,
  input wire logic mem_clk_en_o,
  input wire logic [3:0] mem_select_n_o,
  input wire logic mem_ras_n_o,
  input wire logic mem_cas_n_o,
  input wire logic mem_write_en_n_o,
  input wire logic [13:0] mem_addr_o,
  input wire logic mem_cmd_oe_o,
  // I/O device strobes
  input wire logic io_read_strobe_n_o,
  input wire logic io_write_strobe_n_o,
  input wire logic io_device_enable_n_o,
  input wire logic io_oe_o
);
  logic [2:0] cmd;
  logic pre_all;
  logic act;
  assign cmd = {mem_ras_n_o, mem_cas_n_o, mem_write_en_n_o};
  // A precharge without A10 would leave other banks open
  assign pre_all = mem_cmd_oe_o && cmd == sfb_pkg::CMD_PRE && mem_addr_o[10];
  assign act = mem_cmd_oe_o && cmd == sfb_pkg::CMD_ACT;
  mrs_id_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) mem_cmd_oe_o && cmd == sfb_pkg::CMD_MRS
    |-> cluster_id_i == sfb_pkg::MODE_SET_ID)
    else $error("mode set from a nonzero id");
  sref_entry_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) $fell(host_bus_grant_n_o)
    |-> !mem_clk_en_o && cmd == sfb_pkg::CMD_REF)
    else $error("grant without self-refresh entry");
  pre_grant_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) $fell(host_bus_grant_n_o) |-> $past(pre_all, 2))
    else $error("grant without prior precharge-all");
  host_quiet_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) !host_bus_grant_n_o
    |-> !mem_clk_en_o && cmd != sfb_pkg::CMD_ACT)
    else $error("access while host holds the bus");
  sref_exit_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) $rose(host_bus_grant_n_o) |-> mem_clk_en_o)
    else $error("clock enable low after host release");
  release_pre_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) $fell(bus_master_o) |-> $past(pre_all, 2))
    else $error("bus released without precharge-all");
  chan_zero_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) act |-> flyby_chan_i == sfb_pkg::FLYBY_CHAN)
    else $error("fly-by started on another channel");
  act_first_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) act
    |-> ##2 (cmd == sfb_pkg::CMD_RD || cmd == sfb_pkg::CMD_WR))
    else $error("activate not followed by access");
  one_driver_a: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i) mem_cmd_oe_o == bus_master_o &&
    mem_select_n_o == (bus_master_o ? sfb_pkg::SEL_ACTIVE :
    sfb_pkg::SEL_NONE))
    else $error("select or enable disagrees with ownership");
  io_owner_a: assert property (@(posedge clk_io_i)
    disable iff (sys_rst_i) !io_oe_o
    |-> io_read_strobe_n_o && io_write_strobe_n_o && io_device_enable_n_o)
    else $error("strobe active without ownership");
  io_wr_pulse_a: assert property (@(posedge clk_io_i)
    disable iff (sys_rst_i) $fell(io_write_strobe_n_o)
    |-> io_read_strobe_n_o && io_device_enable_n_o ##1
    !io_write_strobe_n_o ##1 io_write_strobe_n_o)
    else $error("bad write strobe pulse");
  io_rd_pair_a: assert property (@(posedge clk_io_i)
    disable iff (sys_rst_i) !io_read_strobe_n_o
    |-> !io_device_enable_n_o && io_write_strobe_n_o)
    else $error("read strobe without enable");
endmodule
`default_nettype wire

/* File: tb/sfb_io_dev.sv */
// Behavioural external I/O device on the link clock
`timescale 1ns/100ps
`default_nettype none
module sfb_io_dev (
  // Link clock
  input wire logic clk_io_i,
  // One toggle from the bench asks for one word
  input wire logic req_tgl_i,
  // Device pins
  input wire logic io_read_strobe_n_i,
  input wire logic io_write_strobe_n_i,
  input wire logic io_device_enable_n_i,
  input wire logic io_oe_i,
  output logic dma_req_ch_zero_n_o,
  // Words moved
  output int rd_cnt_o,
  output int wr_cnt_o
);
  logic [2:0] tgl_q;
  logic [1:0] low_q;
  logic rd_act, rd_act_q, wr_n, wr_q;
  // Released strobes read as the pull-up level
  assign rd_act = io_oe_i && !io_read_strobe_n_i && !io_device_enable_n_i;
  assign wr_n = !io_oe_i || io_write_strobe_n_i;
  initial begin
    tgl_q = 3'h0;
    low_q = 2'h0;
    rd_act_q = 1'h0;
    wr_q = 1'h1;
    rd_cnt_o = 0;
    wr_cnt_o = 0;
    dma_req_ch_zero_n_o = 1'h1;
  end
  // Strobes are sampled away from the edge that launches them
  always @(negedge clk_io_i) begin
    tgl_q <= {tgl_q[1:0], req_tgl_i};
    // One low pulse, so exactly one falling edge per word
    if (tgl_q[2] != tgl_q[1]) begin
      low_q <= 2'h3;
    end else if (low_q != 2'h0) begin
      low_q <= low_q - 2'h1;
    end
    dma_req_ch_zero_n_o <= low_q == 2'h0;
    rd_act_q <= rd_act;
    wr_q <= wr_n;
    // Sourced only while strobe and enable are both low
    if (rd_act_q && !rd_act) rd_cnt_o <= rd_cnt_o + 1;
    // Captured as the write strobe ends
    if (!wr_q && wr_n) wr_cnt_o <= wr_cnt_o + 1;
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the fly-by SDRAM bus-sharing controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys_i, clk_io_i, sys_rst_i, flyby_wr_i, bus_own_i;
  logic host_bus_req_n_i, host_bus_grant_n_o, bus_master_o;
  logic dma_req_ch_zero_n_i, mem_clk_en_o, mem_ras_n_o, mem_cas_n_o;
  logic mem_write_en_n_o, mem_cmd_oe_o, mem_clk_en_i, mem_ras_n_i;
  logic mem_cas_n_i, mem_write_en_n_i, io_read_strobe_n_o, io_oe_o;
  logic io_write_strobe_n_o, io_device_enable_n_o, sdram_ready_o;
  logic flyby_done_o, req_tgl, p_cke, seen_dir;
  logic [2:0] cluster_id_i, p_cmd, cmd;
  logic [1:0] cas_lat_i, flyby_chan_i;
  logic [3:0] mem_select_n_o, mem_select_n_i, p_sel;
  logic [13:0] flyby_addr_i, mem_addr_o, seen_row;
  logic [14:0] exp_q[$];
  int err_total, total_checks, seed, n_wr, n_rd, rd_cnt, wr_cnt, i;
  // Shared bus: the enabled master drives, else the peer or pull-ups
  assign mem_clk_en_i = mem_cmd_oe_o ? mem_clk_en_o : p_cke;
  assign mem_select_n_i = mem_cmd_oe_o ? mem_select_n_o : p_sel;
  assign cmd = {mem_ras_n_o, mem_cas_n_o, mem_write_en_n_o};
  assign {mem_ras_n_i, mem_cas_n_i, mem_write_en_n_i} =
    mem_cmd_oe_o ? cmd : p_cmd;
  sfb_ctrl #(.PWRUP_CYCLES(20)) i_sfb_ctrl (.clk_sys_i, .sys_rst_i,
    .clk_io_i, .cluster_id_i, .cas_lat_i, .flyby_chan_i, .flyby_wr_i,
    .flyby_addr_i, .bus_own_i, .host_bus_req_n_i, .host_bus_grant_n_o,
    .bus_master_o, .dma_req_ch_zero_n_i, .mem_clk_en_o, .mem_select_n_o,
    .mem_ras_n_o, .mem_cas_n_o, .mem_write_en_n_o, .mem_addr_o,
    .mem_cmd_oe_o, .mem_clk_en_i, .mem_select_n_i, .mem_ras_n_i,
    .mem_cas_n_i, .mem_write_en_n_i, .io_read_strobe_n_o,
    .io_write_strobe_n_o, .io_device_enable_n_o, .io_oe_o,
    .sdram_ready_o, .flyby_done_o);
  sfb_io_dev i_sfb_io_dev (.clk_io_i, .req_tgl_i(req_tgl),
    .io_read_strobe_n_i(io_read_strobe_n_o),
    .io_write_strobe_n_i(io_write_strobe_n_o),
    .io_device_enable_n_i(io_device_enable_n_o), .io_oe_i(io_oe_o),
    .dma_req_ch_zero_n_o(dma_req_ch_zero_n_i), .rd_cnt_o(rd_cnt),
    .wr_cnt_o(wr_cnt));
  initial begin
    clk_sys_i = 1'h0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    clk_io_i = 1'h0;
    #7;
    forever #15 clk_io_i = ~clk_io_i;
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wait_for(ref logic s, input logic v, input string nm);
    int n;
    @(negedge clk_sys_i);
    for (n = 0; n < 80 && s !== v; n++) @(negedge clk_sys_i);
    chk(nm, 16'(v), 16'(s));
    @(posedge clk_sys_i);
  endtask
  // Watcher on the falling edge, where registered outputs have settled
  always @(negedge clk_sys_i) begin
    if (mem_cmd_oe_o && cmd == sfb_pkg::CMD_ACT) seen_row <= mem_addr_o;
    if (!io_write_strobe_n_o) seen_dir <= 1'h0;
    if (!io_read_strobe_n_o) seen_dir <= 1'h1;
    if (flyby_done_o) begin
      if (exp_q.size() == 0) chk("spare done", 16'h0, 16'h1);
      else chk("word", 16'(exp_q.pop_front()), {seen_dir, seen_row});
    end
  end
  task automatic word(input logic wr);
    logic [13:0] row;
    int n;
    row = 14'($random(seed));
    @(posedge clk_sys_i);
    flyby_wr_i <= wr;
    flyby_addr_i <= row;
    req_tgl <= ~req_tgl;
    exp_q.push_back({wr, row});
    if (wr) n_wr++;
    else n_rd++;
    for (n = 0; n < 300 && exp_q.size() != 0; n++) @(posedge clk_sys_i);
    chk("pending", 16'h0, 16'(exp_q.size()));
    step(12);
  endtask
  // An edge that must be refused: a done pulse would find no note
  task automatic poke();
    @(posedge clk_sys_i);
    req_tgl <= ~req_tgl;
    step(60);
  endtask
  task automatic peer(input logic [2:0] c);
    @(posedge clk_sys_i);
    p_sel <= sfb_pkg::SEL_ACTIVE;
    p_cmd <= c;
    @(posedge clk_sys_i);
    p_sel <= sfb_pkg::SEL_NONE;
    p_cmd <= sfb_pkg::CMD_NOP;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #60000;
    err_total++;
    test_done();
  end
  initial begin
    seed = 18117;
    sys_rst_i = 1'h1;
    cluster_id_i = 3'h1;
    cas_lat_i = 2'h2;
    flyby_chan_i = 2'h0;
    flyby_wr_i = 1'h0;
    flyby_addr_i = 14'h0000;
    bus_own_i = 1'h0;
    host_bus_req_n_i = 1'h1;
    req_tgl = 1'h0;
    p_cke = 1'h1;
    p_sel = 4'hF;
    p_cmd = 3'h7;
    step(16);
    sys_rst_i <= 1'h0;
    step(40);
    chk("grant idle", 16'h1, 16'(host_bus_grant_n_o));
    chk("ready early", 16'h0, 16'(sdram_ready_o));
    peer(sfb_pkg::CMD_REF);
    peer(sfb_pkg::CMD_MRS);
    wait_for(sdram_ready_o, 1'h1, "ready seen");
    poke();
    $display("end of slave test");
    bus_own_i <= 1'h1;
    wait_for(bus_master_o, 1'h1, "master");
    for (i = 0; i < 6; i++) word(i[0]);
    chk("io reads", 16'(n_wr), 16'(rd_cnt));
    chk("io writes", 16'(n_rd), 16'(wr_cnt));
    flyby_chan_i <= 2'h1;
    poke();
    flyby_chan_i <= 2'h0;
    $display("end of fly-by test");
    host_bus_req_n_i <= 1'h0;
    wait_for(host_bus_grant_n_o, 1'h0, "grant");
    chk("cke in host", 16'h0, 16'(mem_clk_en_o));
    poke();
    host_bus_req_n_i <= 1'h1;
    wait_for(host_bus_grant_n_o, 1'h1, "ungrant");
    chk("cke after", 16'h1, 16'(mem_clk_en_o));
    step(12);
    word(1'h1);
    $display("end of host test");
    bus_own_i <= 1'h0;
    wait_for(bus_master_o, 1'h0, "released");
    step(10);
    poke();
    $display("end of release test");
    sys_rst_i <= 1'h1;
    cluster_id_i <= 3'h0;
    bus_own_i <= 1'h1;
    step(16);
    sys_rst_i <= 1'h0;
    step(40);
    chk("ready before init", 16'h0, 16'(sdram_ready_o));
    wait_for(sdram_ready_o, 1'h1, "own mode set");
    $display("end of init test");
    test_done();
  end
endmodule
bind sfb_ctrl sfb_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_sfb_props (
  .clk_sys_i, .sys_rst_i, .clk_io_i, .cluster_id_i, .flyby_chan_i,
  .host_bus_grant_n_o, .bus_master_o, .mem_clk_en_o, .mem_select_n_o,
  .mem_ras_n_o, .mem_cas_n_o, .mem_write_en_n_o, .mem_addr_o,
  .mem_cmd_oe_o, .io_read_strobe_n_o, .io_write_strobe_n_o,
  .io_device_enable_n_o, .io_oe_o);
`default_nettype wire
